// file: inc/mppf_pkg.sv
// Purpose: Shared constants and types of the measurement post-processing filter
// Assumes: Samples are signed integers, one LSB = 1 nm
// Notes: Register addresses are word indices on the plain register port
package mppf_pkg;
  // ********************************
  // Widths
  // ********************************
  localparam int SW = 32; // Sample width
  localparam int KEY_KW = 40; // Key lock counter width
  localparam int DECW = 22; // Decimation counter width

  // ********************************
  // Filter modes
  // ********************************
  typedef enum logic [1:0] {
    MPPF_MOV = 2'b00, // Moving average
    MPPF_REC = 2'b01, // Recursive average
    MPPF_MED = 2'b10 // Median
  } mppf_mode_t;

  // ********************************
  // Register addresses
  // ********************************
  localparam logic [3:0] A_CTRL = 4'h0;
  localparam logic [3:0] A_MOV = 4'h1;
  localparam logic [3:0] A_REC = 4'h2;
  localparam logic [3:0] A_MED = 4'h3;
  localparam logic [3:0] A_MVAL = 4'h4;
  localparam logic [3:0] A_CMD = 4'h5;
  localparam logic [3:0] A_STLG = 4'h6;
  localparam logic [3:0] A_DECN = 4'h7;
  localparam logic [3:0] A_DECEN = 4'h8;
  localparam logic [3:0] A_STAT = 4'h9;
  localparam logic [3:0] A_OFS = 4'hA;
  localparam logic [3:0] A_RES = 4'hB;
  localparam logic [3:0] A_MIN = 4'hC;
  localparam logic [3:0] A_MAX = 4'hD;
  localparam logic [3:0] A_P2P = 4'hE;

  // ********************************
  // Field positions
  // ********************************
  localparam int CMD_MASTER = 0;
  localparam int CMD_ZERO = 1;
  localparam int CMD_MRST = 2;
  localparam int CMD_SRST = 3;
  localparam int DE_LOCK = 3; // Key lock enable in A_DECEN
  localparam int ST_MACT = 0;
  localparam int ST_REJ = 1;
  localparam int ST_LOCK = 2;

  // ********************************
  // Reset values and limits
  // ********************************
  localparam mppf_mode_t RST_MODE = MPPF_MOV;
  localparam logic [3:0] RST_MOV_LG = 4'h2; // Window of 4
  localparam logic [3:0] MOV_LG_MAX = 4'hC; // Window of 4096
  localparam logic [15:0] RST_REC_N = 16'h0001;
  localparam logic [15:0] REC_N_MAX = 16'h8000;
  localparam logic [3:0] RST_MED_N = 4'h3;
  localparam logic [3:0] RST_ST_LG = 4'h1;
  localparam logic [3:0] ST_LG_MAX = 4'hE; // Window of 16384
  localparam logic [DECW-1:0] RST_DEC_N = 22'h000001;
  localparam logic [DECW-1:0] DEC_N_MAX = 22'h2DC6C0;
  localparam logic [2:0] RST_DEC_EN = 3'h0;
  localparam logic signed [SW-1:0] MVAL_MAX = 32'sh01479B30; // 21.47 mm

  // ********************************
  // Timing
  // ********************************
  localparam longint unsigned CLK_HZ = 25000000;
  localparam longint unsigned KEY_LOCK_MIN = 5;
  localparam longint unsigned KEY_LOCK_CYC = KEY_LOCK_MIN * 60 * CLK_HZ;
endpackage

// file: inc/mppf_stat_if.sv
// Purpose: Carrier between the filter core and the statistics unit
// Assumes: One clock domain
// Notes: The statistics side drives the results from flip-flops
interface mppf_stat_if;
  import mppf_pkg::*;
  logic signed [SW-1:0] smp; // Result sample
  logic vld; // Sample strobe
  logic [3:0] lg; // Log2 of window length
  logic clr; // Restart evaluation
  logic signed [SW-1:0] mn; // Window minimum
  logic signed [SW-1:0] mx; // Window maximum
  logic signed [SW-1:0] pp; // Peak to peak
  modport src(output smp, vld, lg, clr, input mn, mx, pp);
  modport stat(input smp, vld, lg, clr, output mn, mx, pp);
endinterface

// file: rtl/mppf_stats.sv
// Purpose: Sliding min, max and peak-to-peak of the result stream
// Assumes: Window length 2**lg with lg from 1 to 14
// Notes: Windows above 8 use 8 sub-blocks; the span is W-L+1 to W
module mppf_stats
  import mppf_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  mppf_stat_if.stat st
);
  // ********************************
  // State
  // ********************************
  logic signed [SW-1:0] bmin [0:7]; // Completed block minima
  logic signed [SW-1:0] bmax [0:7]; // Completed block maxima
  logic signed [SW-1:0] cmin, cmax; // Current partial block
  logic cany; // Partial block holds a sample
  logic [13:0] bcnt; // Position inside block
  logic [3:0] bfull; // Completed blocks held
  logic [3:0] blg, nblk, used;
  logic signed [SW-1:0] nmin, nmax, wmin, wmax;

  // Block length and count from window size
  assign blg = (st.lg > 4'h3) ? st.lg - 4'h3 : 4'h0;
  assign nblk = (st.lg > 4'h3) ? 4'h8 : (4'h1 << st.lg[1:0]);
  assign used = (bfull < nblk - 4'h1) ? bfull : nblk - 4'h1;

  always_comb begin
    nmin = (cany && cmin < st.smp) ? cmin : st.smp;
    nmax = (cany && cmax > st.smp) ? cmax : st.smp;
    wmin = nmin;
    wmax = nmax;
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < used) begin
        if (bmin[i] < wmin) begin
          wmin = bmin[i];
        end
        if (bmax[i] > wmax) begin
          wmax = bmax[i];
        end
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i || st.clr) begin
      cany <= 1'b0;
      bcnt <= 14'h0000;
      bfull <= 4'h0;
      st.mn <= '0;
      st.mx <= '0;
      st.pp <= '0;
    end else if (st.vld) begin
      st.mn <= wmin;
      st.mx <= wmax;
      st.pp <= wmax - wmin;
      if (bcnt == (14'h0001 << blg) - 14'h0001) begin
        // Block complete: push it into the history
        bcnt <= 14'h0000;
        cany <= 1'b0;
        bmin[0] <= nmin;
        bmax[0] <= nmax;
        for (int i = 1; i < 8; i++) begin
          bmin[i] <= bmin[i-1];
          bmax[i] <= bmax[i-1];
        end
        bfull <= (bfull == 4'h8) ? 4'h8 : bfull + 4'h1;
      end else begin
        bcnt <= bcnt + 14'h0001;
        cmin <= nmin;
        cmax <= nmax;
        cany <= 1'b1;
      end
    end
  end
endmodule

// file: rtl/mppf_top.sv
// Purpose: Averaging, master offset, statistics and decimation of samples
// Assumes: One sample strobe at most per clock, registers on a plain port
// Notes: Result leaves two clocks after the sample strobe
//
// The strobed register port and the address map were decided locally.
module mppf_top
  import mppf_pkg::*;
#(
  parameter int MOV_DEPTH = 4096, // Moving average memory depth
  parameter longint unsigned KEY_LOCK = KEY_LOCK_CYC // Key lock delay in cycles
)(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic signed [SW-1:0] raw_sample_i, // Computed measurement
  input wire logic raw_vld_i, // Sample strobe
  input wire logic key_i, // Select key press pulse
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic signed [SW-1:0] res_o, // Offset-corrected result
  output logic res_vld_o, // Every result
  output logic ser_vld_o, // Serial path strobe
  output logic ana_vld_o, // Analog path strobe
  output logic eth_vld_o, // Ethernet path strobe
  output logic signed [SW-1:0] stat_min_o,
  output logic signed [SW-1:0] stat_max_o,
  output logic signed [SW-1:0] stat_p2p_o,
  output logic key_locked_o
);
  localparam int MAW = $clog2(MOV_DEPTH); // Memory address width
  localparam int SUMW = SW + MAW + 1; // Running sum width
  localparam int RW = SW + 17; // Recursive numerator width

  // ********************************
  // Register port decode
  // ********************************
  // Write select for one address
  function automatic logic wsel(input logic w, input logic [3:0] a, input logic [3:0] t);
    return w && (a == t);
  endfunction

  mppf_mode_t mode; // Filter selection
  logic [3:0] mov_lg; // Log2 moving window
  logic [15:0] rec_n; // Recursive weight
  logic [3:0] med_n; // Median window
  logic signed [SW-1:0] mval; // Master value
  logic signed [SW-1:0] offset; // Active offset
  logic mact; // Master active
  logic rej; // Sticky refused write
  logic [3:0] st_lg; // Log2 statistics window
  logic [DECW-1:0] dec_n, dcnt; // Decimation ratio and phase
  logic [2:0] dec_en; // Serial, analog, Ethernet
  logic lock_en; // Key lock enabled
  logic [KEY_KW-1:0] kcnt; // Cycles since key use
  logic cfg_clr, cmd_w, bad_w, key_ok;
  logic signed [SW-1:0] filt_q; // Filtered sample
  logic filt_vld;
  logic signed [SW-1:0] next_filt;
  logic signed [SW-1:0] wv;

  assign wv = $signed(wdata_i);
  assign cmd_w = wsel(wr_i, addr_i, A_CMD);
  assign cfg_clr = wsel(wr_i, addr_i, A_CTRL) | wsel(wr_i, addr_i, A_MOV)
                 | wsel(wr_i, addr_i, A_REC) | wsel(wr_i, addr_i, A_MED);
  assign key_ok = key_i && !key_locked_o;

  // Out of range writes are refused and flagged
  always_comb begin
    bad_w = 1'b0;
    if (wr_i) begin
      unique case (addr_i)
        A_CTRL: bad_w = wdata_i[1:0] == 2'h3;
        A_MOV: bad_w = wdata_i[3:0] > MOV_LG_MAX || wdata_i[31:4] != 28'h0;
        A_REC: bad_w = wdata_i[15:0] == 16'h0000 || wdata_i[15:0] > REC_N_MAX
                       || wdata_i[31:16] != 16'h0000;
        A_MED: bad_w = !(wdata_i == 32'h3 || wdata_i == 32'h5 || wdata_i == 32'h7
                       || wdata_i == 32'h9);
        A_MVAL: bad_w = wv > MVAL_MAX || wv < -MVAL_MAX;
        A_STLG: bad_w = wdata_i[3:0] == 4'h0 || wdata_i[3:0] > ST_LG_MAX
                        || wdata_i[31:4] != 28'h0;
        A_DECN: bad_w = wdata_i[DECW-1:0] == '0 || wdata_i[DECW-1:0] > DEC_N_MAX
                        || wdata_i[31:DECW] != '0;
        default: bad_w = 1'b0;
      endcase
    end
  end

  // ********************************
  // Configuration registers
  // ********************************
  // factory defaults
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mode <= RST_MODE;
      mov_lg <= RST_MOV_LG;
      rec_n <= RST_REC_N;
      med_n <= RST_MED_N;
      mval <= '0;
      st_lg <= RST_ST_LG;
      dec_n <= RST_DEC_N;
      dec_en <= RST_DEC_EN;
      lock_en <= 1'b1;
    end else if (wr_i && !bad_w) begin
      unique case (addr_i)
        A_CTRL: mode <= mppf_mode_t'(wdata_i[1:0]);
        A_MOV: mov_lg <= wdata_i[3:0];
        A_REC: rec_n <= wdata_i[15:0];
        A_MED: med_n <= wdata_i[3:0];
        A_MVAL: mval <= wv;
        A_STLG: st_lg <= wdata_i[3:0];
        A_DECN: dec_n <= wdata_i[DECW-1:0];
        A_DECEN: begin
          dec_en <= wdata_i[2:0];
          lock_en <= wdata_i[DE_LOCK];
        end
        default: ;
      endcase
    end
  end

  // Sticky refusal flag, a new refusal beats the clear
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rej <= 1'b0;
    end else if (bad_w) begin
      rej <= 1'b1;
    end else if (wsel(wr_i, addr_i, A_STAT) && wdata_i[ST_REJ]) begin
      rej <= 1'b0;
    end
  end

  // ********************************
  // Moving average
  // ********************************
  logic signed [SW-1:0] mem [0:MOV_DEPTH-1]; // Sample history
  logic [MAW-1:0] wptr; // Next write slot
  logic [MAW:0] mcnt, nwin; // Samples held, window
  logic signed [SW-1:0] first, leave; // First sample, leaving sample
  logic signed [SUMW-1:0] sum, next_sum;
  logic signed [SW-1:0] mov_mean;

  assign nwin = (MAW+1)'(1) << mov_lg;
  // While refilling, missing history counts as the first sample
  assign leave = (mcnt < nwin) ? first : mem[wptr - nwin[MAW-1:0]];
  assign next_sum = (mcnt == '0) ? (SUMW'(raw_sample_i) <<< mov_lg)
                  : sum + SUMW'(raw_sample_i) - SUMW'(leave);
  assign mov_mean = SW'(next_sum >>> mov_lg);

  // History memory write
  always_ff @(posedge mclk_i) begin
    if (raw_vld_i) begin
      mem[wptr] <= raw_sample_i;
    end
  end

  // Sum, pointer and fill count
  always_ff @(posedge mclk_i) begin
    if (rst_i || cfg_clr) begin
      wptr <= '0;
      mcnt <= '0;
      sum <= '0;
      first <= '0;
    end else if (raw_vld_i) begin
      wptr <= wptr + 1'b1;
      mcnt <= (mcnt == nwin) ? mcnt : mcnt + 1'b1;
      sum <= next_sum;
      if (mcnt == '0) begin
        first <= raw_sample_i;
      end
    end
  end

  // ********************************
  // Recursive average
  // ********************************
  logic signed [SW-1:0] rec_y; // Previous output
  logic rec_any;
  logic signed [RW-1:0] rn, rec_num;

  assign rn = RW'(rec_n);
  assign rec_num = RW'(raw_sample_i) + (rn - RW'(1)) * RW'(rec_y);

  // First sample seeds the average
  always_ff @(posedge mclk_i) begin
    if (rst_i || cfg_clr) begin
      rec_y <= '0;
      rec_any <= 1'b0;
    end else if (raw_vld_i) begin
      rec_y <= rec_any ? SW'(rec_num / rn) : raw_sample_i;
      rec_any <= 1'b1;
    end
  end

  // ********************************
  // Median
  // ********************************
  logic signed [SW-1:0] med_sh [0:8]; // Last samples
  logic signed [SW-1:0] win [0:8]; // Window with new sample
  logic signed [SW-1:0] med_val;
  logic [3:0] med_cnt, med_k;

  assign med_k = (med_cnt + 4'h1 < med_n) ? med_cnt + 4'h1 : med_n;

  // Window including the arriving sample
  always_comb begin
    win[0] = raw_sample_i;
    for (int i = 1; i < 9; i++) begin
      win[i] = med_sh[i-1];
    end
  end

  always_comb begin
    logic [3:0] r;
    r = 4'h0;
    med_val = raw_sample_i;
    for (int i = 0; i < 9; i++) begin
      r = 4'h0;
      for (int j = 0; j < 9; j++) begin
        if (4'(j) < med_k && (win[j] < win[i] || (win[j] == win[i] && j < i))) begin
          r = r + 4'h1;
        end
      end
      if (4'(i) < med_k && r == (med_k >> 1)) begin
        med_val = win[i];
      end
    end
  end

  // Shift history and count fill
  always_ff @(posedge mclk_i) begin
    if (rst_i || cfg_clr) begin
      med_cnt <= 4'h0;
    end else if (raw_vld_i) begin
      med_cnt <= (med_cnt == 4'h9) ? med_cnt : med_cnt + 4'h1;
      for (int i = 0; i < 9; i++) begin
        med_sh[i] <= win[i];
      end
    end
  end

  // ********************************
  // Filter selection
  // ********************************
  always_comb begin
    next_filt = mov_mean;
    unique case (mode)
      MPPF_MOV: next_filt = mov_mean;
      MPPF_REC: next_filt = rec_any ? SW'(rec_num / rn) : raw_sample_i;
      MPPF_MED: next_filt = med_val;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      filt_q <= '0;
      filt_vld <= 1'b0;
    end else begin
      filt_vld <= raw_vld_i && !cfg_clr;
      if (raw_vld_i && !cfg_clr) begin
        filt_q <= next_filt;
      end
    end
  end

  // ********************************
  // Mastering and key lock
  // ********************************
  // reset wins
  always_ff @(posedge mclk_i) begin
    if (rst_i || (cmd_w && wdata_i[CMD_MRST])) begin
      offset <= '0;
      mact <= 1'b0;
    end else if (cmd_w && wdata_i[CMD_ZERO]) begin
      offset <= -filt_q;
      mact <= 1'b1;
    end else if ((cmd_w && wdata_i[CMD_MASTER]) || key_ok) begin
      offset <= mval - filt_q;
      mact <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i || key_ok) begin
      kcnt <= '0;
      key_locked_o <= 1'b0;
    end else begin
      if (kcnt != KEY_KW'(KEY_LOCK)) begin
        kcnt <= kcnt + 1'b1;
      end
      key_locked_o <= lock_en && kcnt == KEY_KW'(KEY_LOCK);
    end
  end

  // ********************************
  // Result and decimation
  // ********************************
  logic keep;
  assign keep = dcnt == '0;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      res_o <= '0;
      res_vld_o <= 1'b0;
      ser_vld_o <= 1'b0;
      ana_vld_o <= 1'b0;
      eth_vld_o <= 1'b0;
    end else begin
      res_vld_o <= filt_vld;
      ser_vld_o <= filt_vld && (!dec_en[0] || keep);
      ana_vld_o <= filt_vld && (!dec_en[1] || keep);
      eth_vld_o <= filt_vld && (!dec_en[2] || keep);
      if (filt_vld) begin
        res_o <= filt_q + offset;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i || wsel(wr_i, addr_i, A_DECN)) begin
      dcnt <= '0;
    end else if (filt_vld) begin
      dcnt <= (dcnt >= dec_n - 1'b1) ? '0 : dcnt + 1'b1;
    end
  end

  // ********************************
  // Statistics
  // ********************************
  mppf_stat_if sif ();
  assign sif.smp = res_o;
  assign sif.vld = res_vld_o;
  assign sif.lg = st_lg;
  assign sif.clr = (cmd_w && wdata_i[CMD_SRST]) || wsel(wr_i, addr_i, A_STLG);
  assign stat_min_o = sif.mn;
  assign stat_max_o = sif.mx;
  assign stat_p2p_o = sif.pp;

  mppf_stats u_stats (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .st(sif.stat)
  );

  // ********************************
  // Read data
  // ********************************
  always_ff @(posedge mclk_i) begin
    if (rst_i || !rd_i) begin
      rdata_o <= 32'h0;
    end else begin
      unique case (addr_i)
        A_CTRL: rdata_o <= {30'h0, mode};
        A_MOV: rdata_o <= {28'h0, mov_lg};
        A_REC: rdata_o <= {16'h0, rec_n};
        A_MED: rdata_o <= {28'h0, med_n};
        A_MVAL: rdata_o <= mval;
        A_STLG: rdata_o <= {28'h0, st_lg};
        A_DECN: rdata_o <= {10'h0, dec_n};
        A_DECEN: rdata_o <= {28'h0, lock_en, dec_en};
        A_STAT: rdata_o <= {29'h0, key_locked_o, rej, mact};
        A_OFS: rdata_o <= offset;
        A_RES: rdata_o <= res_o;
        A_MIN: rdata_o <= sif.mn;
        A_MAX: rdata_o <= sif.mx;
        A_P2P: rdata_o <= sif.pp;
        default: rdata_o <= 32'h0;
      endcase
    end
  end
endmodule

// file: sim/mppf_monitor.sv
// Purpose: Port checker of the post-processing filter
// Assumes: Sees the top ports only, one clock domain
// Notes: Bound to the top module at the foot of this file
module mppf_monitor
  import mppf_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic raw_vld_i,
  input wire logic key_i,
  input wire logic [3:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic signed [SW-1:0] res_o,
  input wire logic res_vld_o,
  input wire logic ser_vld_o,
  input wire logic ana_vld_o,
  input wire logic eth_vld_o,
  input wire logic signed [SW-1:0] stat_min_o,
  input wire logic signed [SW-1:0] stat_max_o,
  input wire logic signed [SW-1:0] stat_p2p_o,
  input wire logic key_locked_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********************************
  // Properties
  // ********************************
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  property p_res_lat;
    raw_vld_i && !(wr_i && addr_i <= A_MED) |-> ##2 res_vld_o;
  endproperty
  a_res_lat: assert property (p_res_lat) else $error("result strobe missing");
  property p_res_src;
    res_vld_o |-> $past(raw_vld_i, 2);
  endproperty
  a_res_src: assert property (p_res_src) else $error("result without sample");
  property p_hold;
    !res_vld_o |-> $stable(res_o);
  endproperty
  a_hold: assert property (p_hold) else $error("result moved");
  property p_paths;
    ser_vld_o || ana_vld_o || eth_vld_o |-> res_vld_o;
  endproperty
  a_paths: assert property (p_paths) else $error("path strobe alone");
  property p_stats;
    stat_max_o >= stat_min_o && stat_p2p_o == stat_max_o - stat_min_o;
  endproperty
  a_stats: assert property (p_stats) else $error("statistics inconsistent");
  property p_rd;
    !$past(rd_i) |-> rdata_o == 32'h0;
  endproperty
  a_rd: assert property (p_rd) else $error("read data outside slot");
  property p_lockkey;
    key_locked_o && key_i |=> key_locked_o;
  endproperty
  a_lockkey: assert property (p_lockkey) else $error("locked key acted");
  property p_unlock;
    key_i && !key_locked_o |=> !key_locked_o [*3];
  endproperty
  a_unlock: assert property (p_unlock) else $error("lock despite press");
endmodule

bind mppf_top mppf_monitor u_mppf_monitor (.mclk_i(mclk_i), .rst_i(rst_i),
  .raw_vld_i(raw_vld_i), .key_i(key_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .res_o(res_o), .res_vld_o(res_vld_o), .ser_vld_o(ser_vld_o),
  .ana_vld_o(ana_vld_o), .eth_vld_o(eth_vld_o), .stat_min_o(stat_min_o),
  .stat_max_o(stat_max_o), .stat_p2p_o(stat_p2p_o), .key_locked_o(key_locked_o));

// file: sim/mppf_src.sv
// Purpose: Model of the measurement calculation stage
// Assumes: One sample per request pulse
// Notes: Sample bus toggles outside its strobe
module mppf_src
  import mppf_pkg::*;
(
  input wire logic mclk_i,
  input wire logic go_i,
  input wire logic signed [SW-1:0] val_i,
  output logic signed [SW-1:0] raw_sample_o = '0,
  output logic raw_vld_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // Strobe follows request; idle data is scrambled
  always @(posedge mclk_i) begin
    raw_vld_o <= go_i;
    if (go_i) begin
      raw_sample_o <= val_i;
    end else begin
      raw_sample_o <= ~raw_sample_o;
    end
  end
endmodule

// file: sim/mppf_tb_top.sv
// Purpose: Register driven tests of the post-processing filter
// Assumes: Key lock shortened to 50 cycles
// Notes: Results checked after their strobe
module mppf_tb_top
  import mppf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ********************************
  // Signals
  // ********************************
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic go = 1'b0;
  logic signed [SW-1:0] val = '0;
  logic key = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic signed [SW-1:0] raw, res, smin, smax, sp2p;
  logic raw_vld, res_vld, ser, ana, eth, locked;
  int miscompares = 0;
  int compares = 0;
  int cyc = 0;
  int nser = 0;
  int nana = 0;
  int neth = 0;
  int n0, m0, k0;
  mppf_src u_mppf_src (.mclk_i(mclk_i), .go_i(go), .val_i(val), .raw_sample_o(raw),
    .raw_vld_o(raw_vld));
  mppf_top #(.KEY_LOCK(50)) u_mppf_top (.mclk_i(mclk_i), .rst_i(rst_i), .raw_sample_i(raw),
    .raw_vld_i(raw_vld), .key_i(key), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .res_o(res), .res_vld_o(res_vld), .ser_vld_o(ser),
    .ana_vld_o(ana), .eth_vld_o(eth), .stat_min_o(smin), .stat_max_o(smax),
    .stat_p2p_o(sp2p), .key_locked_o(locked));
  always #20 mclk_i = ~mclk_i;
  // Cycle ceiling and path strobe counts
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    nser <= nser + int'(ser === 1'b1);
    nana <= nana + int'(ana === 1'b1);
    neth <= neth + int'(eth === 1'b1);
    if (cyc == 5000) begin
      miscompares = miscompares + 1;
      summarize();
    end
  end
  // ********************************
  // Tasks
  // ********************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    #1 chk(rdata, e);
    @(posedge mclk_i);
  endtask
  // Send one sample, wait for its result
  task automatic put(input logic [31:0] v, input logic [31:0] e);
    int n;
    val <= v;
    go <= 1'b1;
    @(posedge mclk_i);
    go <= 1'b0;
    #1;
    for (n = 0; n < 6 && res_vld !== 1'b1; n++) #40;
    chk(res_vld, 1'b1);
    chk(res, e);
    @(posedge mclk_i);
  endtask
  task automatic press();
    key <= 1'b1;
    @(posedge mclk_i);
    key <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic summarize();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ********************************
  // Test sequence
  // ********************************
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    chk(locked, 1'b0);
    rd_reg(A_CTRL, 32'h0);
    rd_reg(A_MOV, 32'h2);
    rd_reg(A_DECN, 32'h1);
    rd_reg(A_DECEN, 32'h8);
    rd_reg(A_STLG, 32'h1);
    rd_reg(4'hF, 32'h0);
    repeat (60) @(posedge mclk_i);
    chk(locked, 1'b1);
    press();
    rd_reg(A_OFS, 32'h0);
    wr_reg(A_MOV, 32'hD);
    wr_reg(A_CTRL, 32'h3);
    rd_reg(A_MOV, 32'h2);
    rd_reg(A_STAT, 32'h6);
    wr_reg(A_STAT, 32'h2);
    put(32'h4, 32'h4);
    put(32'h8, 32'h5);
    put(32'hC, 32'h7);
    put(32'h10, 32'hA);
    put(32'h14, 32'hE);
    wr_reg(A_CTRL, 32'h2);
    put(32'h5, 32'h5);
    put(32'h1, 32'h5);
    put(32'h9, 32'h5);
    put(32'h3, 32'h3);
    wr_reg(A_MED, 32'h5);
    put(32'h2, 32'h2);
    put(32'h4, 32'h4);
    put(32'h1, 32'h2);
    put(32'h5, 32'h4);
    put(32'h3, 32'h3);
    put(32'h9, 32'h4);
    wr_reg(A_CTRL, 32'h1);
    wr_reg(A_REC, 32'h4);
    put(32'h64, 32'h64);
    put(32'hC8, 32'h7D);
    put(32'h0, 32'h5D);
    wr_reg(A_CTRL, 32'h0);
    wr_reg(A_MOV, 32'h0);
    wr_reg(A_MVAL, 32'h3E8);
    put(32'h12C, 32'h12C);
    wr_reg(A_CMD, 32'h1);
    rd_reg(A_OFS, 32'h2BC);
    rd_reg(A_STAT, 32'h5);
    put(32'h32, 32'h2EE);
    wr_reg(A_CMD, 32'h2);
    put(32'h3C, 32'hA);
    wr_reg(A_CMD, 32'h4);
    put(32'h3C, 32'h3C);
    wr_reg(A_MVAL, 32'h01479B31);
    rd_reg(A_MVAL, 32'h3E8);
    rd_reg(A_STAT, 32'h6);
    wr_reg(A_STAT, 32'h2);
    wr_reg(A_STLG, 32'h1);
    put(32'hA, 32'hA);
    put(32'h1E, 32'h1E);
    put(32'h14, 32'h14);
    repeat (2) @(posedge mclk_i);
    chk(smin, 32'h14);
    chk(smax, 32'h1E);
    chk(sp2p, 32'hA);
    wr_reg(A_CMD, 32'h8);
    put(32'h7, 32'h7);
    repeat (2) @(posedge mclk_i);
    chk(smin, 32'h7);
    chk(smax, 32'h7);
    wr_reg(A_DECN, 32'h3);
    wr_reg(A_DECEN, 32'hD);
    n0 = nser;
    m0 = nana;
    k0 = neth;
    for (int i = 0; i < 6; i++) put(32'h5, 32'h5);
    // Let the strobe counters take the last edge before reading them
    #1;
    chk(nser - n0, 32'h2);
    chk(nana - m0, 32'h6);
    chk(neth - k0, 32'h2);
    wr_reg(A_DECEN, 32'h0);
    repeat (2) @(posedge mclk_i);
    chk(locked, 1'b0);
    wr_reg(A_MVAL, 32'h1F4);
    put(32'h28, 32'h28);
    press();
    put(32'h28, 32'h1F4);
    summarize();
  end
endmodule
